// [common/rx_baseband_pkg.sv]
// Purpose: Constants and types for the receive baseband control block.
// Assumes: Registers written and read through a serial port built elsewhere.
// Notes: Offsets are the seven-bit register addresses.
// Notes on behaviour
// - Prefilter code picks 100/150/230/340 kHz cut-off.
// - Filter clock divides crystal by twice the 6-bit value.
// - Filter clock runs twenty times the cut-off.
// - Bypass bit routes signal around filter.
// - Demodulator gives up per one, down per zero.
// - Mode: off, up only, down only, up-down.
// - Symbol field spans 8..64 symbols, 00 gives 8.
// - Result readable as 8-bit value at 0x16.
// - Negative results two's complement, down modes only.
// - Counter wraps modulo 256, never saturates.
// - Synchronizer active in receive with sync enabled.
// - Sync disabled: data passes through, no clock.
// - Data clock runs at the bit rate.
// - Recovered bit driven at data clock rising edge.
// - Sync clock is crystal over K times 2^(7-S).
// - Reference divider is 6-bit, 1 to 63, shared.
// - Synchronizer setting accepts values 0 to 7.
// - Reference divider also drives modulator, bit rate clocks.
// - Lock within 22 bits from worst phase.
package rx_baseband_pkg;
  localparam logic [6:0] ADDR_RX_FILTER = 7'h01;
  localparam logic [6:0] ADDR_SYNC_SEL_A = 7'h06;
  localparam logic [6:0] ADDR_SYNC_SEL_B = 7'h07;
  localparam logic [6:0] ADDR_SC_DIV = 7'h08;
  localparam logic [6:0] ADDR_FE_CTRL = 7'h15;
  localparam logic [6:0] ADDR_FE_RESULT = 7'h16;
  localparam logic [7:0] RST_RX_FILTER = 8'h80;
  localparam logic [7:0] RST_SYNC_SEL_A = 8'h00;
  localparam logic [7:0] RST_SYNC_SEL_B = 8'h01;
  localparam logic [7:0] RST_SC_DIV = 8'hc1;
  localparam logic [7:0] RST_FE_CTRL = 8'h00;
  // Fixed-value bits of the filter and divider registers
  localparam logic [7:0] FIX_RX_FILTER = 8'h80;
  localparam logic [7:0] FIX_SC_DIV = 8'hc0;
  localparam logic [7:0] MASK_RX_FILTER = 8'h0f;
  localparam logic [7:0] MASK_SYNC_A = 8'h8f;
  localparam logic [7:0] MASK_SC_DIV = 8'h3f;
  localparam logic [7:0] MASK_FE_CTRL = 8'h0f;
  localparam int SC_CLK_RATIO = 20;
  localparam int SC_CUTOFF_RATIO = 40;
  localparam logic [7:0] SYNC_LOG2 = 8'h07;
  localparam logic [4:0] OVERSAMPLE = 5'h10;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  localparam logic [4:0] LOCK_BITS = 5'h16;
  localparam logic [6:0] SYMBOLS_BASE = 7'h08;
  localparam logic [8:0] PF_KHZ_0 = 9'h064;
  localparam logic [8:0] PF_KHZ_1 = 9'h096;
  localparam logic [8:0] PF_KHZ_2 = 9'h0e6;
  localparam logic [8:0] PF_KHZ_3 = 9'h154;
  typedef enum logic [1:0] {FE_OFF, FE_UP, FE_DOWN, FE_UPDOWN} fe_mode_t;
  typedef struct packed {
    logic [2:0] synchronizer_clock_setting;
    logic [2:0] bit_rate_clock_setting;
    logic [5:0] ref_divider;
  } sync_cfg_t;
  typedef struct packed {
    logic [1:0] symbol_count_sel;
    fe_mode_t estimator_mode;
  } fe_cfg_t;
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage : rx_baseband_pkg

// [hdl/rx_baseband_control.sv]
// Purpose: Prefilter, filter clock, error estimator and bit synchronizer control.
// Assumes: Register requests arrive already decoded from the serial port.
// Notes: Ticks derived as one-cycle enables from i_clock; filter and data clocks are registered levels.
module rx_baseband_control
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register port
  input wire rx_baseband_pkg::reg_req_t i_req,
  input wire logic i_req_valid,
  output logic [7:0] o_rdata,
  // Device state
  input wire logic i_rx_mode,
  input wire logic i_sync_en,
  // Demodulator
  input wire logic i_demod_data,
  input wire logic i_one_pulse,
  input wire logic i_zero_pulse,
  // Analog controls
  output logic [1:0] o_prefilter_cutoff,
  output logic [8:0] o_prefilter_khz,
  output logic o_main_filter_bypass,
  output logic o_sc_filter_clock,
  output logic o_signal_level_enable,
  output logic o_lock_detect_enable,
  // Shared divider ticks
  output logic o_modulator_tick,
  output logic o_bit_rate_tick,
  // Host data link
  output logic o_data_io_pin,
  output logic o_data_io_pin_oe,
  output logic o_data_clock_pin,
  output logic o_data_clock_pin_oe,
  input wire logic i_host_ready,
  output logic o_bit_valid,
  output logic o_sync_locked
);
  import rx_baseband_pkg::*;

  // Register images
  logic [7:0] rx_filter;
  logic [7:0] sync_sel_a;
  logic [7:0] sync_sel_b;
  logic [7:0] sc_div;
  logic [7:0] fe_ctrl;
  logic [7:0] fe_result;

  // Measurement length in symbols: 8 doubled per code step
  function automatic logic [6:0] symbol_span(input logic [1:0] sel);
    symbol_span = SYMBOLS_BASE << sel;
  endfunction : symbol_span

  // Low-bit mask of the power-of-two prescaler; setting 7 passes every
  // reference tick, setting 0 one in 128
  function automatic logic [7:0] pow_mask(input logic [2:0] setting);
    pow_mask = (8'h01 << (SYNC_LOG2[2:0] - setting)) - 8'h01;
  endfunction : pow_mask

  // Register field views
  wire sync_cfg_t sync_cfg = '{sync_sel_a[3:1], {sync_sel_a[0], sync_sel_b[7:6]},
    sync_sel_b[5:0]};
  wire fe_cfg_t fe_cfg = '{fe_ctrl[3:2], fe_mode_t'(fe_ctrl[1:0])};
  wire [5:0] sc_divider = sc_div[5:0];
  wire wr = i_req_valid & i_req.we;
  // A zero divider would stall every derived clock, so it acts as one
  wire [5:0] ref_k = (sync_cfg.ref_divider == 6'h00) ? 6'h01 :
    sync_cfg.ref_divider;
  wire sync_active = i_rx_mode & i_sync_en;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_filter <= RST_RX_FILTER;
      sync_sel_a <= RST_SYNC_SEL_A;
      sync_sel_b <= RST_SYNC_SEL_B;
      sc_div <= RST_SC_DIV;
      fe_ctrl <= RST_FE_CTRL;
    end
    else if (wr)
    begin
      // The result address is read-only, so writes to it fall through
      if (i_req.addr == ADDR_RX_FILTER)
        rx_filter <= FIX_RX_FILTER | (i_req.wdata & MASK_RX_FILTER);
      if (i_req.addr == ADDR_SYNC_SEL_A)
        sync_sel_a <= i_req.wdata & MASK_SYNC_A;
      if (i_req.addr == ADDR_SYNC_SEL_B)
        sync_sel_b <= i_req.wdata;
      if (i_req.addr == ADDR_SC_DIV)
        sc_div <= i_req.wdata | FIX_SC_DIV;
      if (i_req.addr == ADDR_FE_CTRL)
        fe_ctrl <= i_req.wdata & MASK_FE_CTRL;
    end
  end

  // Read mux; unmapped addresses read zero
  logic [7:0] next_rdata;
  always_comb
  begin
    unique case (i_req.addr)
      ADDR_RX_FILTER: next_rdata = rx_filter;
      ADDR_SYNC_SEL_A: next_rdata = sync_sel_a;
      ADDR_SYNC_SEL_B: next_rdata = sync_sel_b;
      ADDR_SC_DIV: next_rdata = sc_div;
      ADDR_FE_CTRL: next_rdata = fe_ctrl;
      ADDR_FE_RESULT: next_rdata = fe_result;
      default: next_rdata = 8'h00;
    endcase
  end

  // Analog controls
  logic [8:0] next_pf_khz;
  always_comb
  begin
    unique case (rx_filter[1:0])
      2'b00: next_pf_khz = PF_KHZ_0;
      2'b01: next_pf_khz = PF_KHZ_1;
      2'b10: next_pf_khz = PF_KHZ_2;
      2'b11: next_pf_khz = PF_KHZ_3;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= 8'h00;
      o_prefilter_cutoff <= 2'b00;
      o_prefilter_khz <= PF_KHZ_0;
      o_signal_level_enable <= 1'b0;
      o_lock_detect_enable <= 1'b0;
    end
    else
    begin
      if (i_req_valid && !i_req.we) o_rdata <= next_rdata;
      o_prefilter_cutoff <= rx_filter[1:0];
      o_prefilter_khz <= next_pf_khz;
      o_signal_level_enable <= rx_filter[3];
      o_lock_detect_enable <= rx_filter[2];
    end
  end

  // Switched-capacitor clock: toggles every div cycles, period 2*div, i.e.
  // twenty times fxco/(40*div). Bypass sits in the spare top bit of 0x06;
  // the estimator control's bit 7 is masked and always reads zero.
  logic [5:0] sc_cnt;
  wire [5:0] sc_div_eff = (sc_divider == 6'h00) ? 6'h01 : sc_divider;
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sc_cnt <= 6'h00;
      o_sc_filter_clock <= 1'b0;
      o_main_filter_bypass <= 1'b0;
    end
    else
    begin
      o_main_filter_bypass <= fe_ctrl[7] | sync_sel_a[7];
      if (sc_cnt >= sc_div_eff - 6'h01)
      begin
        sc_cnt <= 6'h00;
        o_sc_filter_clock <= ~o_sc_filter_clock;
      end
      else
        sc_cnt <= sc_cnt + 6'h01;
    end
  end

  // Shared reference divider and power-of-two prescalers
  logic [5:0] ref_cnt;
  logic [7:0] pow_cnt;
  // One reference count feeds all three rates, so a divider change moves them together
  wire ref_tick = (ref_cnt >= ref_k - 6'h01);
  wire sync_tick = ref_tick &
    ((pow_cnt & pow_mask(sync_cfg.synchronizer_clock_setting)) == 8'h00);
  wire rate_tick = ref_tick &
    ((pow_cnt & pow_mask(sync_cfg.bit_rate_clock_setting)) == 8'h00);
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ref_cnt <= 6'h00;
      pow_cnt <= 8'h00;
      o_modulator_tick <= 1'b0;
      o_bit_rate_tick <= 1'b0;
    end
    else
    begin
      ref_cnt <= ref_tick ? 6'h00 : ref_cnt + 6'h01;
      if (ref_tick) pow_cnt <= pow_cnt + 8'h01;
      o_modulator_tick <= ref_tick;
      o_bit_rate_tick <= rate_tick;
    end
  end

  // Frequency error estimator; wraps freely at 8 bits
  // Result only moves at the end of a whole window, so a read never sees a
  // half-counted value; switching the mode off clears the running count.
  logic [7:0] fe_count;
  logic [10:0] fe_edges;
  logic [6:0] fe_symbols;
  wire fe_on = fe_cfg.estimator_mode != FE_OFF;
  wire fe_sym_edge = sync_tick & (fe_edges[3:0] == 4'hf);
  wire up_en = i_one_pulse &
    ((fe_cfg.estimator_mode == FE_UP) | (fe_cfg.estimator_mode == FE_UPDOWN));
  wire dn_en = i_zero_pulse &
    ((fe_cfg.estimator_mode == FE_DOWN) | (fe_cfg.estimator_mode == FE_UPDOWN));
  // Opposite pulses in one cycle cancel in up-down mode
  wire [7:0] fe_delta = (up_en & ~dn_en) ? 8'h01 :
    (dn_en & ~up_en & (fe_cfg.estimator_mode == FE_UPDOWN)) ? 8'hff :
    (dn_en & (fe_cfg.estimator_mode == FE_DOWN)) ? 8'hff : 8'h00;
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fe_count <= 8'h00;
      fe_result <= 8'h00;
      fe_edges <= 11'h000;
      fe_symbols <= 7'h00;
    end
    else if (!fe_on)
    begin
      fe_count <= 8'h00;
      fe_symbols <= 7'h00;
      fe_edges <= 11'h000;
    end
    else
    begin
      if (sync_tick) fe_edges <= fe_edges + 11'h001;
      if (fe_sym_edge && fe_symbols >= symbol_span(fe_cfg.symbol_count_sel) - 7'h01)
      begin
        fe_result <= fe_count + fe_delta;
        fe_count <= 8'h00;
        fe_symbols <= 7'h00;
      end
      else
      begin
        fe_count <= fe_count + fe_delta;
        if (fe_sym_edge) fe_symbols <= fe_symbols + 7'h01;
      end
    end
  end

  // Bit synchronizer: sixteen phases per bit, nudged one phase per data edge
  logic [3:0] phase;
  logic [4:0] lock_cnt;
  logic sync_prev;
  logic [1:0] buf_valid;
  logic [1:0] buf_data;
  wire data_edge = sync_tick & (i_demod_data ^ sync_prev);
  wire mid = sync_tick & (phase == MID_SAMPLE);
  wire bit_end = sync_tick & (phase == OVERSAMPLE[3:0] - 4'h1);
  wire buf_in_ready = ~buf_valid[1]; // Buffer stalls sampling only if host stops
  wire buf_pop = bit_end & buf_valid[0] & i_host_ready;
  // A stalled host keeps the shown bit; sampling goes on while a slot is
  // free, so one stalled bit period loses nothing
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      phase <= 4'h0;
      lock_cnt <= 5'h00;
      sync_prev <= 1'b0;
      buf_valid <= 2'b00;
      buf_data <= 2'b00;
    end
    else if (!sync_active)
    begin
      phase <= 4'h0;
      lock_cnt <= 5'h00;
      buf_valid <= 2'b00;
    end
    else
    begin
      if (sync_tick) sync_prev <= i_demod_data;
      // Late edge pulls phase back, early edge pushes forward; worst case 8 steps
      if (data_edge && phase != 4'h0)
        phase <= (phase < MID_SAMPLE + 4'h1) ? phase : phase + 4'h2;
      else if (sync_tick)
        phase <= phase + 4'h1;
      if (bit_end && lock_cnt < LOCK_BITS) lock_cnt <= lock_cnt + 5'h01;
      if (mid && buf_in_ready)
      begin
        if (buf_valid[0] && !buf_pop)
        begin
          buf_data[1] <= i_demod_data;
          buf_valid[1] <= 1'b1;
        end
        else if (buf_pop && buf_valid[1])
        begin
          buf_data[0] <= buf_data[1];
          buf_data[1] <= i_demod_data;
        end
        else
        begin
          buf_data[0] <= i_demod_data;
          buf_valid[0] <= 1'b1;
        end
      end
      else if (buf_pop)
      begin
        buf_data[0] <= buf_data[1];
        buf_valid <= {1'b0, buf_valid[1]};
      end
    end
  end

  // Host pins
  // Data pin drives whenever receiving; the clock pin only while
  // synchronizing, so the host sees no stray edges in transparent mode
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_data_io_pin <= 1'b0;
      o_data_io_pin_oe <= 1'b0;
      o_data_clock_pin <= 1'b0;
      o_data_clock_pin_oe <= 1'b0;
      o_bit_valid <= 1'b0;
      o_sync_locked <= 1'b0;
    end
    else
    begin
      o_data_io_pin_oe <= i_rx_mode;
      o_data_clock_pin_oe <= sync_active;
      o_sync_locked <= sync_active & (lock_cnt >= LOCK_BITS);
      o_bit_valid <= buf_pop;
      if (!sync_active)
      begin
        o_data_io_pin <= i_demod_data;
        o_data_clock_pin <= 1'b0;
      end
      else
      begin
        // One clock period per bit; data changes with the rising edge
        if (buf_pop) o_data_io_pin <= buf_data[0];
        if (bit_end) o_data_clock_pin <= 1'b1;
        else if (mid) o_data_clock_pin <= 1'b0;
      end
    end
  end
endmodule : rx_baseband_control

// [dv/rx_baseband_control_checker.sv]
// Purpose: Port checks for rx_baseband_control.
// Assumes: Divider shadows follow writes seen on the request port.
// Notes: Period checks wait out reload transients after any write.
module rx_baseband_control_checker import rx_baseband_pkg::*;
(
  // Clock, reset, register port
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire rx_baseband_pkg::reg_req_t i_req,
  input wire logic i_req_valid,
  input wire logic [7:0] o_rdata,
  // Receive path and host link
  input wire logic i_rx_mode,
  input wire logic i_sync_en,
  input wire logic i_demod_data,
  input wire logic [1:0] o_prefilter_cutoff,
  input wire logic [8:0] o_prefilter_khz,
  input wire logic o_signal_level_enable,
  input wire logic o_lock_detect_enable,
  input wire logic o_sc_filter_clock,
  input wire logic o_modulator_tick,
  input wire logic o_data_io_pin,
  input wire logic o_data_clock_pin,
  input wire logic o_data_clock_pin_oe,
  input wire logic o_sync_locked
);
  logic [5:0] div;
  logic [5:0] k;
  logic [7:0] quiet;
  logic [7:0] gap_sc;
  logic [7:0] gap_mod;
  logic sc_q;
  wire wr = i_req_valid && i_req.we;
  wire rd = i_req_valid && !i_req.we;
  wire [5:0] k_eff = (k == 6'h00) ? 6'h01 : k;
  wire [1:0] pc = o_prefilter_cutoff;
  wire [8:0] khz = pc[1] ? (pc[0] ? PF_KHZ_3 : PF_KHZ_2) : (pc[0] ? PF_KHZ_1 : PF_KHZ_0);
  wire [7:0] lo_rd = {4'h8, o_signal_level_enable, o_lock_detect_enable, pc};
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
    begin
      div <= 6'h01;
      k <= 6'h01;
      quiet <= 8'h00;
      gap_sc <= 8'h00;
      gap_mod <= 8'h00;
      sc_q <= 1'b0;
    end
    else
    begin
      if (wr && i_req.addr == ADDR_SC_DIV)
        div <= i_req.wdata[5:0];
      if (wr && i_req.addr == ADDR_SYNC_SEL_B)
        k <= i_req.wdata[5:0];
      // Saturates so a long quiet spell never looks fresh
      quiet <= wr ? 8'h00 : ((quiet == 8'hff) ? quiet : quiet + 8'h01);
      sc_q <= o_sc_filter_clock;
      gap_sc <= (o_sc_filter_clock != sc_q) ? 8'h01 : gap_sc + 8'h01;
      gap_mod <= o_modulator_tick ? 8'h01 : gap_mod + 8'h01;
    end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_prefilter_table: assert property ($stable(pc) |-> o_prefilter_khz == khz)
    else $error("prefilter kHz does not match code");
  a_readback_filter: assert property (rd && i_req.addr == ADDR_RX_FILTER |=> o_rdata == lo_rd)
    else $error("filter register read does not match outputs");
  a_rdata_holds: assert property (!rd |=> $stable(o_rdata))
    else $error("read data moved without a read");
  a_sc_half_period: assert property ($changed(o_sc_filter_clock) && quiet > 8'hc8
    |-> gap_sc == {2'b00, div})
    else $error("filter clock half period wrong");
  a_mod_tick_gap: assert property (o_modulator_tick && quiet > 8'hc8
    |-> gap_mod == {2'b00, k_eff})
    else $error("modulator tick spacing wrong");
  a_data_on_rise: assert property (o_sync_locked && $past(o_sync_locked)
    && $changed(o_data_io_pin) |-> $rose(o_data_clock_pin))
    else $error("data moved away from clock rise");
  a_clock_off: assert property (!i_sync_en && !$past(i_sync_en) |-> !o_data_clock_pin_oe)
    else $error("data clock driven in async mode");
  a_pass_through: assert property (i_rx_mode && !i_sync_en && $past(i_rx_mode)
    && !$past(i_sync_en) |-> o_data_io_pin == $past(i_demod_data))
    else $error("async data not passed through");
  a_lock_needs_sync: assert property (!i_sync_en |=> !o_sync_locked)
    else $error("locked without sync mode");
endmodule : rx_baseband_control_checker

bind rx_baseband_control rx_baseband_control_checker chk_i (.*);

// [dv/host_mcu_model.sv]
// Purpose: Host side of the data link: samples bits, may stall.
// Assumes: Driven from the same clock as the block.
// Notes: A stalled host takes no bit, so lost words show up.
module host_mcu_model
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Link
  input wire logic i_data_clock_pin,
  input wire logic i_data_io_pin,
  input wire logic i_bit_valid,
  input wire logic i_stall,
  output logic o_host_ready,
  output logic [7:0] o_bits,
  output logic [7:0] o_period
);
  logic clk_q;
  // A rise without a fresh bit repeats the old one; skip its sample
  logic fresh;
  logic [7:0] cnt;
  assign o_host_ready = !i_stall;
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
    begin
      clk_q <= 1'b0;
      fresh <= 1'b0;
      cnt <= 8'h00;
      o_bits <= 8'h00;
      o_period <= 8'h00;
    end
    else
    begin
      clk_q <= i_data_clock_pin;
      cnt <= (i_data_clock_pin && !clk_q) ? 8'h01 : cnt + 8'h01;
      if (i_data_clock_pin && !clk_q)
        o_period <= cnt;
      if (i_data_clock_pin && !clk_q)
        fresh <= i_bit_valid;
      if (!i_data_clock_pin && clk_q && fresh)
        o_bits <= {o_bits[6:0], i_data_io_pin};
    end
endmodule : host_mcu_model

// [dv/test_rx_baseband_control.sv]
// Purpose: Self-checking bench for rx_baseband_control.
// Assumes: Sync tick every cycle (K 1, setting 7), so a bit is 16 cycles.
// Notes: Inputs change on the falling clock edge.
module test_rx_baseband_control import rx_baseband_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  reg_req_t i_req = '0;
  logic i_req_valid = 1'b0;
  logic i_rx_mode = 1'b1;
  logic i_sync_en = 1'b0;
  logic i_demod_data = 1'b0;
  logic i_one_pulse = 1'b0;
  logic i_zero_pulse = 1'b0;
  logic stall = 1'b0;
  logic i_host_ready;
  logic [7:0] o_rdata, host_bits, period, pat = 8'hd2;
  logic [1:0] o_prefilter_cutoff;
  logic [8:0] o_prefilter_khz;
  logic o_main_filter_bypass, o_sc_filter_clock, o_signal_level_enable;
  logic o_lock_detect_enable, o_modulator_tick, o_bit_rate_tick, o_data_io_pin;
  logic o_data_io_pin_oe, o_data_clock_pin, o_data_clock_pin_oe, o_bit_valid, o_sync_locked;
  logic [3:0] ph = 4'h0;
  logic [2:0] bi = 3'h0;
  logic use_pat = 1'b0;
  int up_n = 0;
  int dn_n = 0;
  int fail_count = 0;
  int compares = 0;
  rx_baseband_control dut (.*);
  host_mcu_model host (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_data_clock_pin(o_data_clock_pin),
    .i_data_io_pin(o_data_io_pin), .i_bit_valid(o_bit_valid), .i_stall(stall),
    .o_host_ready(i_host_ready),
    .o_bits(host_bits), .o_period(period));
  initial
    forever #4 i_clock = ~i_clock;
  // Pulses spread one per slot so every pulse is a separate cycle
  always @(negedge i_clock)
  begin
    ph <= ph + 4'h1;
    if (ph == 4'hf)
      bi <= bi + 3'h1;
    i_one_pulse <= !ph[0] && ph[3:1] < up_n;
    i_zero_pulse <= ph[0] && ph[3:1] < dn_n;
    if (use_pat)
      i_demod_data <= pat[~bi];
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask : cyc
  task automatic acc(input logic we, input logic [6:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_req = '{we, a, d};
    i_req_valid = 1'b1;
    @(negedge i_clock);
    i_req_valid = 1'b0;
  endtask : acc
  task automatic t_reset;
    logic [6:0] ad [7] = '{7'h01, 7'h06, 7'h07, 7'h08, 7'h15, 7'h16, 7'h7f};
    logic [7:0] rv [7] = '{8'h80, 8'h00, 8'h01, 8'hc1, 8'h00, 8'h00, 8'h00};
    chk(o_prefilter_khz, 12'h064);
    acc(1'b1, ADDR_FE_RESULT, 8'h5a);
    for (int i = 0; i < 7; i++)
    begin
      acc(1'b0, ad[i], 8'h00);
      chk(o_rdata, rv[i]);
    end
  endtask : t_reset
  task automatic t_prefilter;
    logic [8:0] kz [4] = '{9'h064, 9'h096, 9'h0e6, 9'h154};
    for (int c = 0; c < 4; c++)
    begin
      acc(1'b1, ADDR_RX_FILTER, {4'h8, c[1:0], c[1:0]});
      cyc(1);
      chk(o_prefilter_khz, kz[c]);
      chk(o_lock_detect_enable, c[0]);
    end
    acc(1'b1, ADDR_SYNC_SEL_A, 8'h80);
    cyc(1);
    chk(o_main_filter_bypass, 1'b1);
    acc(1'b1, ADDR_SYNC_SEL_A, 8'h00);
    cyc(1);
    chk(o_main_filter_bypass, 1'b0);
  endtask : t_prefilter
  task automatic t_transparent;
    for (int v = 1; v >= 0; v--)
    begin
      i_demod_data = v[0];
      cyc(3);
      chk(o_data_io_pin, v[0]);
      chk(o_data_io_pin_oe, 1'b1);
    end
  endtask : t_transparent
  task automatic t_estimator;
    logic [1:0] md [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
    int sl [5] = '{0, 1, 2, 3, 3};
    int up [5] = '{1, 0, 2, 3, 2};
    int dn [5] = '{0, 1, 1, 3, 3};
    logic [7:0] ex [5] = '{8'h08, 8'hf0, 8'h20, 8'hc0, 8'h40};
    acc(1'b1, ADDR_SYNC_SEL_A, 8'h0e);
    acc(1'b1, ADDR_SYNC_SEL_B, 8'h01);
    i_sync_en = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      up_n = up[i];
      dn_n = dn[i];
      acc(1'b1, ADDR_FE_CTRL, {4'h0, sl[i][1:0], md[i]});
      // Three windows so the last latched one is whole
      cyc(384 << sl[i]);
      acc(1'b0, ADDR_FE_RESULT, 8'h00);
      chk(o_rdata, ex[i]);
    end
    i_sync_en = 1'b0;
  endtask : t_estimator
  task automatic t_sync;
    logic hit;
    use_pat = 1'b1;
    i_sync_en = 1'b1;
    cyc(16 * 24);
    chk(o_sync_locked, 1'b1);
    chk(period, 12'h010);
    stall = 1'b1;
    cyc(16);
    stall = 1'b0;
    cyc(16 * 5);
    hit = 1'b0;
    for (int r = 0; r < 8; r++)
      hit |= (host_bits === ((pat << r) | (pat >> (8 - r))));
    chk(hit, 1'b1);
    i_sync_en = 1'b0;
    use_pat = 1'b0;
    cyc(2);
    chk(o_sync_locked, 1'b0);
  endtask : t_sync
  task automatic t_divider;
    int tg;
    int mt;
    int bt;
    logic last;
    acc(1'b1, ADDR_SC_DIV, 8'h05);
    acc(1'b0, ADDR_SC_DIV, 8'h00);
    chk(o_rdata, 8'hc5);
    acc(1'b1, ADDR_SYNC_SEL_B, 8'h03);
    cyc(20);
    tg = 0;
    mt = 0;
    bt = 0;
    last = o_sc_filter_clock;
    repeat (3840)
    begin
      @(negedge i_clock);
      tg += (o_sc_filter_clock !== last);
      last = o_sc_filter_clock;
      mt += o_modulator_tick;
      bt += o_bit_rate_tick;
    end
    chk(tg[11:0], 12'h300);
    chk(mt[11:0], 12'h500);
    chk(bt[11:0], 12'h00a);
  endtask : t_divider
  task automatic print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (30000) @(posedge i_clock);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    repeat (2) @(negedge i_clock);
    i_rst_n = 1'b1;
    t_reset();
    t_prefilter();
    t_transparent();
    t_estimator();
    t_sync();
    t_divider();
    print_verdict();
  end
endmodule : test_rx_baseband_control
